//--- rtl/ieflu_unit.sv
// Purpose: Interrupt mask and flag registers, pin change and external interrupt detection.
// Assumes: Pins and timer events are synchronous to clk_sys_in; timer events are one-cycle pulses.
// Notes: The core acknowledges a taken vector with vector_ack_in and returns with reti_in.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ieflu_unit (
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Pins, alternate function masks and sense control.
   input wire ieflu_pkg::ieflu_pins_t pins_in,
   input wire logic [10:0] alt_func_mask_in,
   input wire logic [1:0] sense_ctl_in,
   // Timer events.
   input wire ieflu_pkg::ieflu_timer_ev_t timer_ev_in,
   // Core handshake and wake sampling.
   input wire logic vector_ack_in,
   input wire logic reti_in,
   input wire logic wdt_clk_en_in,
   output logic irq_out,
   output logic [3:0] irq_vector_out,
   output logic global_en_out,
   output logic wake_out
);
   ieflu_pkg::ieflu_state_t state_reg;
   ieflu_pkg::ieflu_state_t state_next;

   always_comb begin
      logic [10:0] pins_now;
      logic [10:0] changed;
      logic pc_set;
      logic ext_set;
      logic ext_level;
      logic ext_req;
      logic [7:0] gf_clr;
      logic [7:0] tf_clr;
      logic [7:0] tf_set;
      logic [7:0] gf_set;
      logic [7:0] wbyte;
      logic do_wr;
      logic do_rd;
      logic [3:0] vec;
      logic [7:0] raddr;
      state_next = state_reg;
      pins_now = {pins_in.port_b[7:4], pins_in.port_a_hi, pins_in.port_b[3:0]};
      changed = (pins_now ^ state_reg.pins_prev) & ~alt_func_mask_in;
      // Upper group bits 10..4, lower group bits 3..0.
      pc_set = (state_reg.gen_mask[ieflu_pkg::BIT_PCU] & (|changed[10:4]))
         | (state_reg.gen_mask[ieflu_pkg::BIT_PCL] & (|changed[3:0]));
      ext_set = 1'b0;
      // The pin is observed even when driven as an output by the port.
      case (sense_ctl_in)
         ieflu_pkg::SENSE_ANY: ext_set = pins_in.ext_pin ^ state_reg.ext_prev;
         ieflu_pkg::SENSE_FALL: ext_set = state_reg.ext_prev & ~pins_in.ext_pin;
         ieflu_pkg::SENSE_RISE: ext_set = ~state_reg.ext_prev & pins_in.ext_pin;
         default: ext_set = 1'b0;
      endcase
      ext_level = (sense_ctl_in == ieflu_pkg::SENSE_LOW) & ~pins_in.ext_pin;
      state_next.pins_prev = pins_now;
      state_next.ext_prev = pins_in.ext_pin;
      do_wr = 1'b0;
      do_rd = 1'b0;
      wbyte = state_reg.wdata[7:0];
      raddr = s_axi_araddr_in;
      gf_clr = 8'h00;
      tf_clr = 8'h00;
      // Bus slave.
      case (state_reg.bus)
         ieflu_pkg::BUS_IDLE: begin
            if (s_axi_awvalid_in && !state_reg.awseen) begin
               state_next.awseen = 1'b1;
               state_next.awaddr = s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !state_reg.wseen) begin
               state_next.wseen = 1'b1;
               state_next.wdata = s_axi_wdata_in;
               if (!s_axi_wstrb_in[0]) begin
                  state_next.wdata = 32'h0000_0000;
               end
            end
            if (state_reg.awseen && state_reg.wseen) begin
               do_wr = 1'b1;
               state_next.awseen = 1'b0;
               state_next.wseen = 1'b0;
               state_next.bus = ieflu_pkg::BUS_WRESP;
            end else if (s_axi_arvalid_in && !state_reg.awseen && !state_reg.wseen) begin
               do_rd = 1'b1;
               state_next.bus = ieflu_pkg::BUS_RRESP;
            end
         end
         ieflu_pkg::BUS_WRESP: begin
            if (s_axi_bready_in) begin
               state_next.bus = ieflu_pkg::BUS_IDLE;
            end
         end
         ieflu_pkg::BUS_RRESP: begin
            if (s_axi_rready_in) begin
               state_next.bus = ieflu_pkg::BUS_IDLE;
            end
         end
         default: state_next.bus = ieflu_pkg::BUS_IDLE;
      endcase
      if (do_wr) begin
         state_next.bresp = ieflu_pkg::RESP_OKAY;
         if (state_reg.awaddr == ieflu_pkg::ADDR_TIMER_FLAGS) begin
            tf_clr = wbyte & ieflu_pkg::TIMER_USED;
         end else if (state_reg.awaddr == ieflu_pkg::ADDR_TIMER_MASK) begin
            state_next.timer_mask = wbyte & ieflu_pkg::TIMER_USED;
         end else if (state_reg.awaddr == ieflu_pkg::ADDR_GEN_MASK) begin
            state_next.gen_mask = wbyte & ieflu_pkg::GEN_MASK_USED;
         end else if (state_reg.awaddr == ieflu_pkg::ADDR_GEN_FLAGS) begin
            gf_clr = wbyte & ieflu_pkg::GEN_FLAG_USED;
         end else if (state_reg.awaddr == ieflu_pkg::ADDR_CONTROL) begin
            state_next.global_en = wbyte[0];
         end else if (state_reg.awaddr != ieflu_pkg::ADDR_STATUS) begin
            state_next.bresp = ieflu_pkg::RESP_SLVERR;
         end
      end
      if (do_rd) begin
         state_next.rresp = ieflu_pkg::RESP_OKAY;
         state_next.rdata = 32'h0000_0000;
         if (raddr == ieflu_pkg::ADDR_TIMER_FLAGS) begin
            state_next.rdata[7:0] = state_reg.timer_flags;
         end else if (raddr == ieflu_pkg::ADDR_TIMER_MASK) begin
            state_next.rdata[7:0] = state_reg.timer_mask;
         end else if (raddr == ieflu_pkg::ADDR_GEN_MASK) begin
            state_next.rdata[7:0] = state_reg.gen_mask;
         end else if (raddr == ieflu_pkg::ADDR_GEN_FLAGS) begin
            state_next.rdata[7:0] = state_reg.gen_flags;
         end else if (raddr == ieflu_pkg::ADDR_CONTROL) begin
            state_next.rdata[0] = state_reg.global_en;
         end else if (raddr == ieflu_pkg::ADDR_STATUS) begin
            state_next.rdata[7:0] = {state_reg.wake, state_reg.irq, 2'h0, state_reg.vector};
         end else begin
            state_next.rresp = ieflu_pkg::RESP_SLVERR;
         end
      end
      // Timer 1 flag clears wait one synchronization cycle; timer 0 clears at once.
      state_next.sync_clr = {tf_clr[ieflu_pkg::BIT_CMPA], tf_clr[ieflu_pkg::BIT_CMPB],
         tf_clr[ieflu_pkg::BIT_T1OVF]};
      tf_clr[ieflu_pkg::BIT_CMPA] = state_reg.sync_clr[2];
      tf_clr[ieflu_pkg::BIT_CMPB] = state_reg.sync_clr[1];
      tf_clr[ieflu_pkg::BIT_T1OVF] = state_reg.sync_clr[0];
      // A vector taken by the core clears its own flag.
      if (vector_ack_in) begin
         case (state_reg.vector)
            ieflu_pkg::VEC_EXT: gf_clr[ieflu_pkg::BIT_EXT] = 1'b1;
            ieflu_pkg::VEC_PINCHG: gf_clr[ieflu_pkg::BIT_PCF] = 1'b1;
            ieflu_pkg::VEC_CMPA: tf_clr[ieflu_pkg::BIT_CMPA] = 1'b1;
            ieflu_pkg::VEC_CMPB: tf_clr[ieflu_pkg::BIT_CMPB] = 1'b1;
            ieflu_pkg::VEC_T1OVF: tf_clr[ieflu_pkg::BIT_T1OVF] = 1'b1;
            ieflu_pkg::VEC_T0OVF: tf_clr[ieflu_pkg::BIT_T0OVF] = 1'b1;
            default: tf_clr = tf_clr;
         endcase
      end
      gf_set = 8'h00;
      gf_set[ieflu_pkg::BIT_EXT] = ext_set;
      gf_set[ieflu_pkg::BIT_PCF] = pc_set;
      tf_set = 8'h00;
      tf_set[ieflu_pkg::BIT_CMPA] = timer_ev_in.cmp_a;
      tf_set[ieflu_pkg::BIT_CMPB] = timer_ev_in.cmp_b;
      tf_set[ieflu_pkg::BIT_T1OVF] = timer_ev_in.t1_ovf;
      tf_set[ieflu_pkg::BIT_T0OVF] = timer_ev_in.t0_ovf;
      state_next.gen_flags = ((state_reg.gen_flags & ~gf_clr) | gf_set)
         & ieflu_pkg::GEN_FLAG_USED;
      state_next.timer_flags = ((state_reg.timer_flags & ~tf_clr) | tf_set)
         & ieflu_pkg::TIMER_USED;
      if (sense_ctl_in == ieflu_pkg::SENSE_LOW) begin
         state_next.gen_flags[ieflu_pkg::BIT_EXT] = 1'b0;
      end
      // Pending requests ranked by vector address, lowest first.
      ext_req = state_reg.gen_mask[ieflu_pkg::BIT_EXT]
         & (state_reg.gen_flags[ieflu_pkg::BIT_EXT] | ext_level);
      vec = ieflu_pkg::VEC_NONE;
      if (ext_req) begin
         vec = ieflu_pkg::VEC_EXT;
      end else if (state_reg.gen_flags[ieflu_pkg::BIT_PCF]
         && (state_reg.gen_mask[ieflu_pkg::BIT_PCU] || state_reg.gen_mask[ieflu_pkg::BIT_PCL])) begin
         vec = ieflu_pkg::VEC_PINCHG;
      end else if (state_reg.timer_flags[ieflu_pkg::BIT_CMPA]
         && state_reg.timer_mask[ieflu_pkg::BIT_CMPA]) begin
         vec = ieflu_pkg::VEC_CMPA;
      end else if (state_reg.timer_flags[ieflu_pkg::BIT_CMPB]
         && state_reg.timer_mask[ieflu_pkg::BIT_CMPB]) begin
         vec = ieflu_pkg::VEC_CMPB;
      end else if (state_reg.timer_flags[ieflu_pkg::BIT_T1OVF]
         && state_reg.timer_mask[ieflu_pkg::BIT_T1OVF]) begin
         vec = ieflu_pkg::VEC_T1OVF;
      end else if (state_reg.timer_flags[ieflu_pkg::BIT_T0OVF]
         && state_reg.timer_mask[ieflu_pkg::BIT_T0OVF]) begin
         vec = ieflu_pkg::VEC_T0OVF;
      end
      // While a vector is acknowledged the request drops; entry clears the global enable.
      if (vector_ack_in && state_reg.irq) begin
         state_next.global_en = 1'b0;
         state_next.irq = 1'b0;
         state_next.vector = ieflu_pkg::VEC_NONE;
      end else begin
         if (reti_in) begin
            state_next.global_en = 1'b1;
         end
         state_next.irq = state_reg.global_en && (vec != ieflu_pkg::VEC_NONE);
         state_next.vector = state_reg.global_en ? vec : ieflu_pkg::VEC_NONE;
      end
      // Wake: two consecutive watchdog-rate samples must both show the level.
      state_next.wake = 1'b0;
      if (wdt_clk_en_in) begin
         state_next.wake_smp = {state_reg.wake_smp[0], ext_req | (vec != ieflu_pkg::VEC_NONE)};
         state_next.wake = state_reg.wake_smp[0] & (ext_req | (vec != ieflu_pkg::VEC_NONE));
      end
      state_next.wdt_prev = wdt_clk_en_in;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_reg <= '0;
         state_reg.bus <= ieflu_pkg::BUS_IDLE;
         state_reg.gen_mask <= ieflu_pkg::RESET_BYTE;
         state_reg.timer_mask <= ieflu_pkg::RESET_BYTE;
         state_reg.ext_prev <= 1'b1;
         state_reg.pins_prev <= 11'h7FF;
      end else begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      s_axi_awready_out = (state_reg.bus == ieflu_pkg::BUS_IDLE) & ~state_reg.awseen;
      s_axi_wready_out = (state_reg.bus == ieflu_pkg::BUS_IDLE) & ~state_reg.wseen;
   end
   assign s_axi_bvalid_out = (state_reg.bus == ieflu_pkg::BUS_WRESP);
   assign s_axi_bresp_out = state_reg.bresp;
   assign s_axi_arready_out = (state_reg.bus == ieflu_pkg::BUS_IDLE) & ~state_reg.awseen
      & ~state_reg.wseen;
   assign s_axi_rvalid_out = (state_reg.bus == ieflu_pkg::BUS_RRESP);
   assign s_axi_rdata_out = state_reg.rdata;
   assign s_axi_rresp_out = state_reg.rresp;
   assign irq_out = state_reg.irq;
   assign irq_vector_out = state_reg.vector;
   assign global_en_out = state_reg.global_en;
   assign wake_out = state_reg.wake;
endmodule // ieflu_unit

//--- rtl/ieflu_pkg.sv
// Purpose: Constants and carrier types for the interrupt enable and flag unit.
// Assumes: One 20 MHz system clock, synchronous active-high reset, AXI4-Lite register access.
// Notes: Function
// Function
// - External request needs its enable bit and global enable; vector 1.
// - Two-bit sense field picks rising, falling, any change or low level.
// - External pin activity requests even when the pin is an output.
// - Upper group change with upper enable and global enable requests vector 2.
// - Lower group change on port B 3..0 with lower enable requests vector 2.
// - A pin with an active alternate function never sets the change flag.
// - A cleared group enable keeps that group from setting the change flag.
// - External flag sets on matching event; clears on vector or write one.
// - External flag held at zero in low-level sense mode.
// - Change flag sets on enabled unmasked change; clears on vector or write one.
// - Compare A enable with global enable requests vector 3.
// - Compare B enable with global enable requests vector 4.
// - Timer 1 overflow enable with global enable requests vector 5.
// - Timer 0 overflow enable with global enable requests vector 6.
// - Compare A flag sets on match; vector taken clears it.
// - Write one clears compare A flag one synchronization cycle later.
// - Compare B flag sets on match; clears on vector or delayed write one.
// - Timer 1 overflow flag sets on overflow; vector or delayed write one clears.
// - Timer 0 overflow flag clears on vector or immediately on write one.
// - Reserved bits of mask and flag registers read as zero.
// - Low-level mode keeps requesting while the pin stays low.
// - Wake needs two watchdog-clock samples at the required level.
// - Lowest pending vector is served first; reset outranks all.
// - Entry clears global enable; return from interrupt sets it again.
package ieflu_pkg;
   localparam logic [7:0] ADDR_TIMER_FLAGS = 8'h38;
   localparam logic [7:0] ADDR_TIMER_MASK = 8'h3C;
   localparam logic [7:0] ADDR_GEN_MASK = 8'h40;
   localparam logic [7:0] ADDR_GEN_FLAGS = 8'h44;
   localparam logic [7:0] ADDR_CONTROL = 8'h48;
   localparam logic [7:0] ADDR_STATUS = 8'h4C;
   // Bit positions.
   localparam int BIT_EXT = 6;
   localparam int BIT_PCU = 5;
   localparam int BIT_PCL = 4;
   localparam int BIT_PCF = 5;
   localparam int BIT_CMPA = 6;
   localparam int BIT_CMPB = 5;
   localparam int BIT_T1OVF = 2;
   localparam int BIT_T0OVF = 1;
   localparam logic [7:0] GEN_MASK_USED = 8'h70;
   localparam logic [7:0] GEN_FLAG_USED = 8'h60;
   localparam logic [7:0] TIMER_USED = 8'h66;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   localparam logic [3:0] VEC_NONE = 4'h0;
   localparam logic [3:0] VEC_EXT = 4'h1;
   localparam logic [3:0] VEC_PINCHG = 4'h2;
   localparam logic [3:0] VEC_CMPA = 4'h3;
   localparam logic [3:0] VEC_CMPB = 4'h4;
   localparam logic [3:0] VEC_T1OVF = 4'h5;
   localparam logic [3:0] VEC_T0OVF = 4'h6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {BUS_IDLE, BUS_WRESP, BUS_RRESP} ieflu_bus_state_t;

   // Pin inputs: upper group is PB7..4, PA7, PA6, PA3; lower group PB3..0.
   typedef struct packed {
      logic [7:0] port_b;
      logic [2:0] port_a_hi;
      logic ext_pin;
   } ieflu_pins_t;

   typedef struct packed {
      logic cmp_a;
      logic cmp_b;
      logic t1_ovf;
      logic t0_ovf;
   } ieflu_timer_ev_t;

   typedef struct packed {
      ieflu_bus_state_t bus;
      logic awseen;
      logic wseen;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] gen_mask;
      logic [7:0] gen_flags;
      logic [7:0] timer_mask;
      logic [7:0] timer_flags;
      logic [2:0] sync_clr;
      logic global_en;
      logic [10:0] pins_prev;
      logic ext_prev;
      logic [3:0] vector;
      logic irq;
      logic [1:0] wake_smp;
      logic wdt_prev;
      logic wake;
   } ieflu_state_t;
endpackage

//--- test/ieflu_unit_sva.sv
// Purpose: Port assertions for the interrupt enable and flag unit.
// Assumes: One clock domain with synchronous active-high reset.
// Notes: Attached to the unit by the bind at the foot of this file.
`timescale 1ns/1ps
module ieflu_unit_sva (
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // Bus handshakes.
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   // Core side.
   input wire logic vector_ack_in,
   input wire logic reti_in,
   input wire logic wdt_clk_en_in,
   input wire logic irq_out,
   input wire logic [3:0] irq_vector_out,
   input wire logic global_en_out,
   input wire logic wake_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   sequence s_take;
      vector_ack_in && irq_out;
   endsequence
   sequence s_rd_stall;
      s_axi_rvalid_out && !s_axi_rready_in;
   endsequence
   a_take_drops_gie: assert property (s_take |=> !global_en_out ##1 !irq_out)
      else $error("Taken vector left enable or request up.");
   a_reti_sets_gie: assert property (reti_in && !(vector_ack_in && irq_out) |=> global_en_out)
      else $error("Return did not set global enable.");
   a_irq_needs_gie: assert property (!global_en_out [*2] |-> !irq_out)
      else $error("Request without global enable.");
   a_vec_in_range: assert property (irq_out |-> irq_vector_out inside {[4'h1:4'h6]})
      else $error("Request with no valid vector.");
   a_rd_one_cycle: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("Read answer late.");
   a_rd_data_held: assert property (s_rd_stall |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)
      && $stable(s_axi_rresp_out))
      else $error("Read answer not held.");
   a_wr_resp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
      && $stable(s_axi_bresp_out))
      else $error("Write answer not held.");
   a_wake_on_tick: assert property (wake_out |-> $past(wdt_clk_en_in) ##1 !wake_out)
      else $error("Wake pulse off the watchdog tick.");
endmodule // ieflu_unit_sva
bind ieflu_unit ieflu_unit_sva u_sva (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_bresp_out(s_axi_bresp_out), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out),
   .s_axi_rresp_out(s_axi_rresp_out), .vector_ack_in(vector_ack_in), .reti_in(reti_in),
   .wdt_clk_en_in(wdt_clk_en_in), .irq_out(irq_out), .irq_vector_out(irq_vector_out),
   .global_en_out(global_en_out), .wake_out(wake_out));

//--- test/ieflu_core_model.sv
// Purpose: Behavioural processor core that takes vectors and returns from them.
// Assumes: Request from the unit is a registered level.
// Notes: The delay input sets how long a handler runs before its return.
`timescale 1ns/1ps
module ieflu_core_model (
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // Request side.
   input wire logic irq_in,
   input wire logic take_en_in,
   input wire logic [3:0] dly_in,
   // Core handshake.
   output logic ack_out,
   output logic reti_out
);
   logic [3:0] cnt_reg = 4'h0;
   initial begin
      ack_out = 1'b0;
      reti_out = 1'b0;
   end
   // Only an idle core takes a vector, so one handler runs at a time.
   always @(posedge clk_sys_in) begin
      ack_out <= 1'b0;
      reti_out <= 1'b0;
      if (reset_in) begin
         cnt_reg <= 4'h0;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
         reti_out <= (cnt_reg == 4'h1);
      end else if (take_en_in && irq_in && !ack_out) begin
         ack_out <= 1'b1;
         cnt_reg <= dly_in;
      end
   end
endmodule // ieflu_core_model

//--- test/ieflu_unit_tb_top.sv
// Purpose: Self-checking bench for the interrupt enable and flag unit.
// Assumes: Bus, pins and timer events change just after rising edges.
// Notes: Random pin traffic comes from a fixed seed.
`timescale 1ns/1ps
module ieflu_unit_tb_top;
   logic clk, rst, aw_vld, w_vld, b_rdy, ar_vld, r_rdy, ack, reti, wdt, take_en;
   logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, gie, wake;
   logic [7:0] aw_addr, ar_addr;
   logic [31:0] w_data, r_data;
   logic [3:0] w_strb, vec, dly;
   logic [1:0] b_resp, r_resp, sense;
   logic [10:0] alt;
   logic [2:0] wdt_cnt;
   ieflu_pkg::ieflu_pins_t pins;
   ieflu_pkg::ieflu_timer_ev_t tev;
   int err_total, cmp_count, wake_seen;
   logic [3:0] vq[$];

   ieflu_unit uut (.clk_sys_in(clk), .reset_in(rst), .s_axi_awaddr_in(aw_addr),
      .s_axi_awvalid_in(aw_vld), .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(w_data),
      .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_vld), .s_axi_wready_out(w_rdy),
      .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_vld), .s_axi_bready_in(b_rdy),
      .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_vld), .s_axi_arready_out(ar_rdy),
      .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_vld),
      .s_axi_rready_in(r_rdy), .pins_in(pins), .alt_func_mask_in(alt), .sense_ctl_in(sense),
      .timer_ev_in(tev), .vector_ack_in(ack), .reti_in(reti), .wdt_clk_en_in(wdt),
      .irq_out(irq), .irq_vector_out(vec), .global_en_out(gie), .wake_out(wake));
   ieflu_core_model core (.clk_sys_in(clk), .reset_in(rst), .irq_in(irq),
      .take_en_in(take_en), .dly_in(dly), .ack_out(ack), .reti_out(reti));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      wdt_cnt <= wdt_cnt + 3'h1;
      wdt <= (wdt_cnt == 3'h7);
      if (!rst && ack && irq) vq.push_back(vec);
      if (!rst && wake) wake_seen++;
   end

   task automatic wrap_up();
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      aw_addr <= a;
      w_data <= d;
      aw_vld <= 1'b1;
      w_vld <= 1'b1;
      b_rdy <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && aw_rdy) begin
            aw_ok = 1'b1;
            aw_vld <= 1'b0;
         end
         if (!w_ok && w_rdy) begin
            w_ok = 1'b1;
            w_vld <= 1'b0;
         end
      end
      // The response is taken at the edge that samples bvalid high.
      do @(posedge clk); while (!b_vld);
      b_rdy <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      ar_addr <= a;
      ar_vld <= 1'b1;
      r_rdy <= 1'b1;
      do @(posedge clk); while (!ar_rdy);
      ar_vld <= 1'b0;
      // Data and response are taken at the edge that samples rvalid high.
      do @(posedge clk); while (!r_vld);
      d = r_data;
      r = r_resp;
      r_rdy <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk(d, e);
   endtask

   function automatic logic [31:0] ext_exp(input logic [1:0] m, input logic rise);
      logic hit;
      hit = (m == ieflu_pkg::SENSE_ANY);
      hit = hit || (m == (rise ? ieflu_pkg::SENSE_RISE : ieflu_pkg::SENSE_FALL));
      return hit ? 32'h0000_0040 : 32'h0000_0000;
   endfunction

   function automatic logic [31:0] pc_exp(input logic [10:0] o, n, m, input logic [1:0] en);
      logic [10:0] d;
      d = (o ^ n) & ~m & {{7{en[1]}}, {4{en[0]}}};
      return (|d) ? 32'h0000_0020 : 32'h0000_0000;
   endfunction

   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      wrap_up();
   end

   initial begin
      int i;
      logic [10:0] old_v, new_v, msk;
      logic [1:0] en, rr;
      logic [31:0] rv;
      rst = 1'b1;
      {aw_vld, w_vld, b_rdy, ar_vld, r_rdy, wdt, take_en} = '0;
      {aw_addr, ar_addr, w_data, wdt_cnt, alt, tev} = '0;
      w_strb = 4'h1;
      dly = 4'h4;
      pins = '1;
      sense = ieflu_pkg::SENSE_LOW;
      {err_total, cmp_count, wake_seen} = '0;
      old_v = '1;
      void'($urandom(70501));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) rd_chk(8'h38 + 8'(4 * i), 32'h0000_0000);
      axr(8'h50, rv, rr);
      chk({30'h0, rr}, {30'h0, ieflu_pkg::RESP_SLVERR});
      axw(ieflu_pkg::ADDR_GEN_MASK, 32'h0000_00ff);
      rd_chk(ieflu_pkg::ADDR_GEN_MASK, 32'h0000_0070);
      axw(ieflu_pkg::ADDR_TIMER_MASK, 32'h0000_00ff);
      rd_chk(ieflu_pkg::ADDR_TIMER_MASK, 32'h0000_0066);
      for (i = 0; i < 2; i++) begin
         @(posedge clk) tev <= '1;
         @(posedge clk) tev <= '0;
         if (i == 0) begin
            rd_chk(ieflu_pkg::ADDR_TIMER_FLAGS, 32'h0000_0066);
            axw(ieflu_pkg::ADDR_TIMER_FLAGS, 32'h0000_0002);
            rd_chk(ieflu_pkg::ADDR_TIMER_FLAGS, 32'h0000_0064);
            axw(ieflu_pkg::ADDR_TIMER_FLAGS, 32'h0000_0064);
            rd_chk(ieflu_pkg::ADDR_TIMER_FLAGS, 32'h0000_0000);
         end
      end
      take_en <= 1'b1;
      dly <= 4'(4 + $urandom_range(0, 7));
      axw(ieflu_pkg::ADDR_CONTROL, 32'h0000_0001);
      while (vq.size() < 4 || !gie) @(posedge clk);
      for (i = 0; i < 4; i++) chk(32'(vq[i]), 32'(i + 3));
      take_en <= 1'b0;
      rd_chk(ieflu_pkg::ADDR_TIMER_FLAGS, 32'h0000_0000);
      axw(ieflu_pkg::ADDR_CONTROL, 32'h0000_0000);
      for (i = 0; i < 4; i++) begin
         sense <= 2'(i);
         pins.ext_pin <= 1'b0;
         axw(ieflu_pkg::ADDR_GEN_FLAGS, 32'h0000_0060);
         @(posedge clk) pins.ext_pin <= 1'b1;
         rd_chk(ieflu_pkg::ADDR_GEN_FLAGS, ext_exp(2'(i), 1'b1));
         axw(ieflu_pkg::ADDR_GEN_FLAGS, 32'h0000_0060);
         @(posedge clk) pins.ext_pin <= 1'b0;
         rd_chk(ieflu_pkg::ADDR_GEN_FLAGS, ext_exp(2'(i), 1'b0));
      end
      sense <= ieflu_pkg::SENSE_LOW;
      for (i = 0; i < 24; i++) begin
         en = 2'($urandom);
         msk = (i < 4) ? 11'h000 : 11'($urandom);
         new_v = 11'($urandom);
         axw(ieflu_pkg::ADDR_GEN_MASK, {26'h0, en, 4'h0});
         @(posedge clk) alt <= msk;
         @(posedge clk) pins.port_b <= {new_v[10:7], new_v[3:0]};
         pins.port_a_hi <= new_v[6:4];
         rd_chk(ieflu_pkg::ADDR_GEN_FLAGS, pc_exp(old_v, new_v, msk, en));
         axw(ieflu_pkg::ADDR_GEN_FLAGS, 32'h0000_0060);
         old_v = new_v;
      end
      axw(ieflu_pkg::ADDR_GEN_MASK, 32'h0000_0040);
      axw(ieflu_pkg::ADDR_CONTROL, 32'h0000_0001);
      wake_seen = 0;
      repeat (2) @(posedge clk);
      for (i = 0; i < 24; i++) begin
         @(posedge clk);
         chk({27'h0, irq, vec}, {27'h0, 1'b1, ieflu_pkg::VEC_EXT});
      end
      chk(32'(wake_seen > 0), 32'h0000_0001);
      @(posedge clk) pins.ext_pin <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      wrap_up();
   end
endmodule // ieflu_unit_tb_top
